/* File: hw/adcdc_host.sv */
// host end: starts conversions, waits on busy, clocks the chain out
`timescale 1ns/100ps
`include "adcdc_defines.svh"
module adcdc_host
  import adcdc_pkg::*;
#(
  parameter int N_DEV = 3,
  parameter int RES_BITS = `ADCDC_RESULT_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  adcdc_if.host link,
  output logic [N_DEV*RES_BITS-1:0] results,
  output logic results_valid,
  output logic host_busy
);
  localparam int NEDGE = RES_BITS * N_DEV + 1;
  localparam int GUARD = `ADCDC_BUSY_WAIT_CYC;
  initial begin
    if (N_DEV < 1 || NEDGE > 1023) $error("chain length unsupported");
  end
  typedef struct packed {
    logic [1:0] dout_sync;
    adcdc_host_state_t st;
    logic [7:0] tcnt;
    logic [9:0] ecnt;
    logic cs;
    logic sck;
    logic [N_DEV*RES_BITS:0] data;
    logic [N_DEV*RES_BITS-1:0] res;
    logic valid;
    logic busy;
  } adcdc_host_reg_t;
  adcdc_host_reg_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.dout_sync = {s_q.dout_sync[0], link.dout};
    s_d.valid = 1'b0;
    case (s_q.st)
      ADCDC_H_IDLE: begin
        s_d.cs = 1'b0;
        s_d.busy = 1'b0;
        if (start) begin
          s_d.st = ADCDC_H_ACQ;
          s_d.busy = 1'b1;
          s_d.tcnt = `ADCDC_ACQ_CYC;
        end
      end
      ADCDC_H_ACQ: begin
        if (s_q.tcnt == 8'h00) begin
          s_d.cs = 1'b1;
          s_d.st = ADCDC_H_WAITBUSY;
        end else begin
          s_d.tcnt = s_q.tcnt - 8'h01;
        end
      end
      ADCDC_H_WAITBUSY: begin
        if (s_q.dout_sync[1]) begin
          s_d.st = ADCDC_H_GUARD;
          s_d.tcnt = 8'(GUARD);
        end
      end
      ADCDC_H_GUARD: begin
        if (s_q.tcnt == 8'h00) begin
          s_d.cs = 1'b0;
          s_d.sck = 1'b1;
          s_d.ecnt = 10'(NEDGE);
          s_d.tcnt = `ADCDC_SCLK_HALF;
          s_d.st = ADCDC_H_SHIFT;
        end else begin
          s_d.tcnt = s_q.tcnt - 8'h01;
        end
      end
      ADCDC_H_SHIFT: begin
        // sampling just before each fall keeps the full settle of the sync path
        if (s_q.tcnt == 8'h00) begin
          s_d.tcnt = `ADCDC_SCLK_HALF;
          if (s_q.sck) begin
            s_d.sck = 1'b0;
            s_d.ecnt = s_q.ecnt - 10'h001;
            s_d.data = {s_q.data[N_DEV*RES_BITS-1:0], s_q.dout_sync[1]};
          end else if (s_q.ecnt == 10'h000) begin
            s_d.st = ADCDC_H_END;
          end else begin
            s_d.sck = 1'b1;
          end
        end else begin
          s_d.tcnt = s_q.tcnt - 8'h01;
        end
      end
      ADCDC_H_END: begin
        // top bit holds the near busy bit; the rest is the chain, near device first
        s_d.res = s_q.data[N_DEV*RES_BITS-1:0];
        s_d.valid = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = ADCDC_H_IDLE;
      end
      default: begin
        s_d.st = ADCDC_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign link.convert_start_select = s_q.cs;
  assign link.sclk = s_q.sck;
  assign link.chain_in = 1'b0;
  assign results = s_q.res;
  assign results_valid = s_q.valid;
  assign host_busy = s_q.busy;
endmodule

/* File: inc/adcdc_defines.svh */
// timing and layout constants for the daisy-chain readout
`ifndef ADCDC_DEFINES_SVH
`define ADCDC_DEFINES_SVH
`define ADCDC_RESULT_BITS 18
`define ADCDC_CLK_NS 25
`define ADCDC_BUSY_WAIT_NS 50
`define ADCDC_BUSY_WAIT_CYC ((`ADCDC_BUSY_WAIT_NS + `ADCDC_CLK_NS - 1) / `ADCDC_CLK_NS)
`define ADCDC_CONV_CYC 8'h28
`define ADCDC_SCLK_HALF 8'h04
`define ADCDC_ACQ_CYC 8'h10
`endif

/* File: inc/adcdc_pkg.sv */
// types shared by both ends of the daisy-chain readout
package adcdc_pkg;
  typedef enum logic [1:0] {
    ADCDC_ACQ,
    ADCDC_CONV,
    ADCDC_DONE
  } adcdc_dev_state_t;
  typedef enum logic [2:0] {
    ADCDC_H_IDLE,
    ADCDC_H_ACQ,
    ADCDC_H_WAITBUSY,
    ADCDC_H_GUARD,
    ADCDC_H_SHIFT,
    ADCDC_H_END
  } adcdc_host_state_t;
endpackage

/* File: inc/adcdc_if.sv */
// link between one chain device and the host
`timescale 1ns/100ps
interface adcdc_if;
  logic convert_start_select;
  logic sclk;
  logic chain_in;
  logic dout;
  modport device (
    input convert_start_select,
    input sclk,
    input chain_in,
    output dout
  );
  modport host (
    output convert_start_select,
    output sclk,
    output chain_in,
    input dout
  );
endinterface

/* File: hw/adcdc_device.sv */
// one converter of the daisy chain: conversion timing and result shift register
`timescale 1ns/100ps
`include "adcdc_defines.svh"
module adcdc_device
  import adcdc_pkg::*;
#(
  parameter int RES_BITS = `ADCDC_RESULT_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [RES_BITS-1:0] sample_value,
  adcdc_if.device link,
  output logic conv_busy
);
  initial begin
    if (RES_BITS < 2) $error("result width too small");
  end
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] din_sync;
    logic cs_prev;
    logic sck_prev;
    adcdc_dev_state_t st;
    logic [7:0] cnt;
    logic [RES_BITS:0] shreg;
    logic first;
    logic dout;
    logic busy;
  } adcdc_dev_reg_t;
  adcdc_dev_reg_t s_q, s_d;
  logic cs_rise, sck_fall;
  always_comb begin
    s_d = s_q;
    s_d.cs_sync = {s_q.cs_sync[0], link.convert_start_select};
    s_d.sck_sync = {s_q.sck_sync[0], link.sclk};
    s_d.din_sync = {s_q.din_sync[0], link.chain_in};
    s_d.cs_prev = s_q.cs_sync[1];
    s_d.sck_prev = s_q.sck_sync[1];
    cs_rise = s_q.cs_sync[1] && !s_q.cs_prev;
    sck_fall = !s_q.sck_sync[1] && s_q.sck_prev;
    case (s_q.st)
      ADCDC_ACQ: begin
        if (cs_rise) begin
          s_d.st = ADCDC_CONV;
          s_d.cnt = `ADCDC_CONV_CYC;
          s_d.busy = 1'b1;
          // stale read data must not look like a busy bit to the host
          s_d.dout = 1'b0;
        end
      end
      ADCDC_CONV: begin
        // select is ignored here so it can serve other parts meanwhile
        if (s_q.cnt == 8'h00) begin
          // busy bit sits on top of the stored result, msb right below it
          s_d.shreg = {1'b1, sample_value};
          s_d.dout = 1'b1;
          s_d.first = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = ADCDC_DONE;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ADCDC_DONE: begin
        s_d.st = ADCDC_ACQ;
      end
      default: begin
        s_d.st = ADCDC_ACQ;
      end
    endcase
    if (s_q.st != ADCDC_CONV && !s_q.cs_sync[1] && sck_fall) begin
      if (s_q.first) begin
        // the upstream busy bit arrives on this fall and is dropped, so only
        // the near busy bit leaves the chain and 18N+1 falls suffice
        s_d.first = 1'b0;
        s_d.dout = s_q.shreg[RES_BITS-1];
      end else begin
        s_d.shreg = {s_q.shreg[RES_BITS-1:0], s_q.din_sync[1]};
        s_d.dout = s_q.shreg[RES_BITS-2];
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign link.dout = s_q.dout;
  assign conv_busy = s_q.busy;
endmodule

/* File: tb/adcdc_props.sv */
// assertions on the link between the host and the near end of the chain
`timescale 1ns/100ps
module adcdc_props #(
  parameter int N_DEV = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic convert_start_select,
  input wire logic sclk,
  input wire logic chain_in,
  input wire logic dout
);
  ////////////////////////////////////////////////////////////////
  // falls are counted per read; a raised select clears the count
  logic [7:0] nf_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) nf_q <= 8'h00;
    else if (convert_start_select) nf_q <= 8'h00;
    else if ($fell(sclk)) nf_q <= nf_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_first_tied: assert property (!chain_in)
    else $error("chain input not held low");
  a_conv_quiet: assert property ($rose(convert_start_select) |-> !dout [*8])
    else $error("busy bit shown too early");
  a_busy_shown: assert property ($rose(convert_start_select) |-> ##[30:60] dout)
    else $error("busy bit missing after conversion");
  a_busy_guard: assert property ($rose(dout) && convert_start_select |-> convert_start_select [*2])
    else $error("read began without guard delay");
  a_fall_read: assert property ($fell(sclk) |-> !convert_start_select)
    else $error("clock fell outside a read");
  a_sclk_still: assert property (convert_start_select && $past(convert_start_select) |-> $stable(sclk))
    else $error("clock moved during conversion");
  a_half_period: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("clock low phase too short");
  a_fall_count: assert property ($rose(convert_start_select) |-> nf_q == 8'h00 || nf_q == 8'(N_DEV * 18 + 1))
    else $error("wrong number of clock falls in read");
endmodule

/* File: tb/adc_daisy_chain_busy_readout_test.sv */
// self-checking bench: host reads a chain of two converters
`timescale 1ns/100ps
module adc_daisy_chain_busy_readout_test;
  localparam int N = 2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [17:0] s0 = 18'h0_0000;
  logic [17:0] s1 = 18'h0_0000;
  logic [35:0] res;
  logic vld;
  logic hb;
  logic cb0;
  logic cb1;
  int n_mismatch = 0;
  int compares = 0;
  logic [35:0] rows [4] = '{36'hf_ffff_ffff, 36'h0_0000_0000, 36'h8_0002_0001, 36'h5_5555_aaaa};
  adcdc_if hl();
  adcdc_if l0();
  adcdc_if l1();
  assign l0.convert_start_select = hl.convert_start_select;
  assign l1.convert_start_select = hl.convert_start_select;
  assign l0.sclk = hl.sclk;
  assign l1.sclk = hl.sclk;
  assign l0.chain_in = hl.chain_in;
  assign l1.chain_in = l0.dout;
  assign hl.dout = l1.dout;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  adcdc_host #(.N_DEV(N)) i_adcdc_host (.clk(clk), .reset(reset), .start(start), .link(hl),
    .results(res), .results_valid(vld), .host_busy(hb));
  adcdc_device i_adcdc_device_0 (.clk(clk), .reset(reset), .sample_value(s0), .link(l0),
    .conv_busy(cb0));
  adcdc_device i_adcdc_device_1 (.clk(clk), .reset(reset), .sample_value(s1), .link(l1),
    .conv_busy(cb1));
  adcdc_props #(.N_DEV(N)) i_adcdc_props (.clk(clk), .reset(reset),
    .convert_start_select(hl.convert_start_select), .sclk(hl.sclk),
    .chain_in(hl.chain_in), .dout(hl.dout));
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse();
    @(posedge clk);
    #1 start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask
  // one full conversion and read; hangs are cut at 1000 cycles
  task automatic run(input logic [35:0] exp);
    int i;
    pulse();
    i = 0;
    while (vld !== 1'b1 && i < 1000) begin
      @(posedge clk);
      #2 i++;
    end
    if (vld !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    cmp("results", exp, res);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    foreach (rows[k]) begin
      // the near device leaves the chain first, so it fills the high bits
      s1 = rows[k][35:18];
      s0 = rows[k][17:0];
      run(rows[k]);
      $display("row %0d done", k);
    end
    // reset lands in mid-conversion, then a clean read must follow
    pulse();
    repeat (38) @(posedge clk);
    #2 cmp("busy", 36'(2'b11), 36'({cb0, cb1}));
    cmp("host busy", 36'(1'b1), 36'(hb));
    reset = 1'b1;
    #1 cmp("reset results", 36'h0_0000_0000, {res[35:1], vld});
    @(posedge clk);
    #1 reset = 1'b0;
    run(rows[3]);
    $display("mid reset test done");
    final_report();
  end
endmodule
